// >>> common/tcc_consts.vh
// constants for the timer core control block
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// register byte addresses on the bus
`define TCC_ADDR_CTRL        12'h000
`define TCC_ADDR_ROUTE       12'h004
`define TCC_ADDR_CNT_HIGH    12'h008
`define TCC_ADDR_CNT_LOW     12'h00C
`define TCC_ADDR_WRAP_LIMIT  12'h010

// control/status field positions
`define TCC_BIT_WRAP_FLAG    7
`define TCC_BIT_WRAP_IE      6
`define TCC_BIT_HALT         5
`define TCC_BIT_CLEAR        4
`define TCC_SEL_HI           2
`define TCC_SEL_LO           0

// reset values and codes
`define TCC_SEL_EXT          3'h7
`define TCC_SEL_RESET        3'h0
`define TCC_ROUTE_RESET      4'h0
`define TCC_LIMIT_RESET      16'hFFFF
`define TCC_COUNT_ZERO       16'h0000
`define TCC_PRESC_ZERO       6'h00

`endif

// >>> src/tcc_core_control.v
// timer core control: counter, prescaler, status and request routing
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "tcc_consts.vh"

module tcc_core_control #(
    parameter CHANNELS = 4,
    parameter PRESC_W  = 6
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        dmaAccess,
    // system modes
    input  wire        waitMode,
    input  wire        stopMode,
    input  wire        breakActive,
    input  wire        breakFlagClearEnable,
    // external count clock pin
    input  wire        extClockPin,
    input  wire        portDirectionBit,
    output wire        extPinOe,
    // channel flags from channel logic
    input  wire [3:0]  channelFlag,
    input  wire [3:0]  channelIrqEnable,
    input  wire [3:0]  channelBufferedCapable,
    // requests and status
    output wire [3:0]  channelCpuIrq,
    output wire [3:0]  channelDmaReq,
    output wire        wrapIrq,
    output wire        wakeRequest,
    output wire        countTick,
    output reg  [15:0] countValue
);

    // ==========================================================
    // registers
    reg                wrapFlag;
    reg                wrapIrqEnable;
    reg                counterHalt;
    reg  [2:0]         clockSourceSelect;
    reg  [3:0]         channelRequestRoute;
    reg  [15:0]        wrapLimit;
    reg  [PRESC_W-1:0] prescaler;
    reg                wrapClearArmed;
    reg  [7:0]         lowByteLatch;
    reg                lowLatched;
    reg                extSync1;
    reg                extSync2;
    reg                extPrev;

    // ==========================================================
    // next values
    reg                next_wrapFlag;
    reg                next_wrapClearArmed;
    reg                next_wrapIrqEnable;
    reg                next_counterHalt;
    reg  [2:0]         next_clockSourceSelect;
    reg  [3:0]         next_channelRequestRoute;
    reg  [15:0]        next_wrapLimit;
    reg  [PRESC_W-1:0] next_prescaler;
    reg  [15:0]        next_countValue;
    reg  [7:0]         next_lowByteLatch;
    reg                next_lowLatched;
    reg  [31:0]        next_prdata;
    reg  [3:0]         cpuReq;
    reg  [3:0]         dmaReq;
    integer            ch;

    // ==========================================================
    // bus decode
    function regHit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            regHit = (addr == offset);
        end
    endfunction

    wire access     = psel & penable;
    wire setupPhase = psel & ~penable;
    wire allowed    = ~waitMode | dmaAccess;
    wire wrEn       = access & pwrite & allowed;
    wire rdEn       = access & ~pwrite & allowed;
    wire rdSetup    = setupPhase & ~pwrite;
    wire hitCtrl    = regHit(paddr, `TCC_ADDR_CTRL);
    wire hitRte     = regHit(paddr, `TCC_ADDR_ROUTE);
    wire hitHigh    = regHit(paddr, `TCC_ADDR_CNT_HIGH);
    wire hitLow     = regHit(paddr, `TCC_ADDR_CNT_LOW);
    wire hitLim     = regHit(paddr, `TCC_ADDR_WRAP_LIMIT);
    wire mapped  = hitCtrl | hitRte | hitHigh | hitLow | hitLim;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // flag clearing gated in break
    wire clearAllowed = ~breakActive | breakFlagClearEnable;

    // ==========================================================
    // count clock selection
    function ratePulse;
        input [2:0]         sel;
        input [PRESC_W-1:0] p;
        reg   [PRESC_W-1:0] mask;
        begin
            mask = ({PRESC_W{1'b1}} >> (PRESC_W - sel));
            ratePulse = ((p & mask) == mask);
        end
    endfunction

    wire useExt   = (clockSourceSelect == `TCC_SEL_EXT);
    wire extEdge  = extSync2 & ~extPrev;
    wire running  = ~counterHalt & ~stopMode & ~breakActive;
    wire intTick  = ratePulse(clockSourceSelect, prescaler);
    wire tick     = running & (useExt ? extEdge : intTick);
    wire atLimit  = (countValue == wrapLimit);
    wire wrapEvt  = tick & atLimit;
    wire clearCmd = wrEn & hitCtrl & pwdata[`TCC_BIT_CLEAR];

    assign countTick = tick;
    assign extPinOe  = useExt ? 1'b0 : portDirectionBit;

    // ==========================================================
    // synchroniser for the external pin
    always @(posedge ref_clk) begin
        if (rst) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extPrev  <= 1'b0;
        end else begin
            extSync1 <= extClockPin;
            extSync2 <= extSync1;
            extPrev  <= extSync2;
        end
    end

    // ==========================================================
    // prescaler and counter
    always @* begin
        next_prescaler  = prescaler;
        next_countValue = countValue;
        if (clearCmd) begin
            next_prescaler  = `TCC_PRESC_ZERO;
            next_countValue = `TCC_COUNT_ZERO;
        end else begin
            if (running)
                next_prescaler = prescaler + 1'b1;
            if (wrapEvt)
                next_countValue = `TCC_COUNT_ZERO;
            else if (tick)
                next_countValue = countValue + 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            prescaler  <= `TCC_PRESC_ZERO;
            countValue <= `TCC_COUNT_ZERO;
        end else begin
            prescaler  <= next_prescaler;
            countValue <= next_countValue;
        end
    end

    // ==========================================================
    // control and status
    wire flagClear = wrEn & hitCtrl & wrapClearArmed
                     & ~pwdata[`TCC_BIT_WRAP_FLAG] & clearAllowed;
    wire flagArm   = rdEn & hitCtrl & wrapFlag & clearAllowed;

    always @* begin
        next_wrapIrqEnable       = wrapIrqEnable;
        next_counterHalt         = counterHalt;
        next_clockSourceSelect   = clockSourceSelect;
        next_channelRequestRoute = channelRequestRoute;
        next_wrapLimit           = wrapLimit;
        next_wrapFlag            = wrapFlag;
        next_wrapClearArmed      = wrapClearArmed;
        if (wrEn & hitCtrl) begin
            next_wrapIrqEnable     = pwdata[`TCC_BIT_WRAP_IE];
            next_counterHalt       = pwdata[`TCC_BIT_HALT];
            next_clockSourceSelect = pwdata[`TCC_SEL_HI:`TCC_SEL_LO];
        end
        if (wrEn & hitRte)
            next_channelRequestRoute = pwdata[3:0];
        if (wrEn & hitLim)
            next_wrapLimit = pwdata[15:0];
        // set wins; arm holds through break with clear disabled
        if (wrapEvt) begin
            next_wrapFlag       = 1'b1;
            next_wrapClearArmed = 1'b0;
        end else if (flagClear) begin
            next_wrapFlag       = 1'b0;
            next_wrapClearArmed = 1'b0;
        end else if (flagArm) begin
            next_wrapClearArmed = 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            wrapFlag            <= 1'b0;
            wrapClearArmed      <= 1'b0;
            wrapIrqEnable       <= 1'b0;
            counterHalt         <= 1'b1;
            clockSourceSelect   <= `TCC_SEL_RESET;
            channelRequestRoute <= `TCC_ROUTE_RESET;
            wrapLimit           <= `TCC_LIMIT_RESET;
        end else begin
            wrapFlag            <= next_wrapFlag;
            wrapClearArmed      <= next_wrapClearArmed;
            wrapIrqEnable       <= next_wrapIrqEnable;
            counterHalt         <= next_counterHalt;
            clockSourceSelect   <= next_clockSourceSelect;
            channelRequestRoute <= next_channelRequestRoute;
            wrapLimit           <= next_wrapLimit;
        end
    end

    // ==========================================================
    // latched count read
    // taken with the high byte so both halves come from one count
    wire latchTake = rdSetup & allowed & hitHigh & ~lowLatched;

    always @* begin
        next_lowByteLatch = lowByteLatch;
        next_lowLatched   = lowLatched;
        if (clearCmd) begin
            next_lowByteLatch = 8'h00;
            next_lowLatched   = 1'b0;
        end else if (latchTake) begin
            next_lowByteLatch = countValue[7:0];
            next_lowLatched   = 1'b1;
        end else if (rdEn & hitLow) begin
            next_lowLatched   = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            lowByteLatch <= 8'h00;
            lowLatched   <= 1'b0;
        end else begin
            lowByteLatch <= next_lowByteLatch;
            lowLatched   <= next_lowLatched;
        end
    end

    // ==========================================================
    // read data
    // control byte as read; the clear bit always reads zero
    function [7:0] ctrlByte;
        input       flag;
        input       ie;
        input       halt;
        input [2:0] sel;
        begin
            ctrlByte = {flag, ie, halt, 1'b0, 1'b0, sel};
        end
    endfunction

    always @* begin
        next_prdata = prdata;
        if (rdSetup) begin
            next_prdata = 32'h00000000;
            if (hitCtrl)
                next_prdata[7:0] = ctrlByte(wrapFlag, wrapIrqEnable,
                                            counterHalt, clockSourceSelect);
            else if (hitRte)
                next_prdata[3:0] = channelRequestRoute;
            else if (hitHigh)
                next_prdata[7:0] = countValue[15:8];
            else if (hitLow)
                next_prdata[7:0] = lowLatched ? lowByteLatch
                                              : countValue[7:0];
            else if (hitLim)
                next_prdata[15:0] = wrapLimit;
        end
    end

    always @(posedge ref_clk) begin
        if (rst)
            prdata <= 32'h00000000;
        else
            prdata <= next_prdata;
    end

    // ==========================================================
    // channel request routing to cpu or dma
    always @* begin
        cpuReq = 4'h0;
        dmaReq = 4'h0;
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin
            if (channelFlag[ch] & channelIrqEnable[ch]) begin
                if (channelRequestRoute[ch])
                    dmaReq[ch] = ~channelBufferedCapable[ch];
                else
                    cpuReq[ch] = 1'b1;
            end
        end
    end

    assign channelCpuIrq = cpuReq;
    assign channelDmaReq = dmaReq;

    // ==========================================================
    // interrupt and wake
    assign wrapIrq       = wrapFlag & wrapIrqEnable;
    assign wakeRequest   = waitMode & (wrapIrq | (|channelCpuIrq));

endmodule // tcc_core_control

// >>> tb/tb.sv
// self-checking bench for the timer core control block
`timescale 1ns/1ns
`include "tcc_consts.vh"
module tb;
    logic ref_clk = 0, rst = 1, waitMode = 0, stopMode = 0, rndOn = 0;
    logic breakActive = 0, breakFlagClearEnable = 0, extClockPin = 0;
    logic portDirectionBit = 0, chkNext = 0, slvErr = 0;
    logic [3:0] channelFlag = 0, channelIrqEnable = 0;
    logic [3:0] channelBufferedCapable = 0;
    wire psel, penable, pwrite, dmaAccess, pready, pslverr, extPinOe;
    wire wrapIrq, wakeRequest, countTick;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0] channelCpuIrq, channelDmaReq;
    wire [15:0] countValue;
    logic [15:0] lim = 16'hFFFF, expNext, v;
    logic [31:0] rdat, rnd;
    int error_cnt = 0, cmp_count = 0, cyc = 0, ticks = 0, t, s;
    int seed = 32'hfa514ae2;
    initial forever #4 ref_clk = ~ref_clk;
    tcc_apb_master i_bus (.*);
    tcc_core_control i_dut (.*);
    // ==================================================
    // helpers
    task chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input logic dm = 0);
        i_bus.xfer(1'b1, dm, a, d, rdat);
    endtask
    task rd(input [11:0] a, input [31:0] e, input string n);
        i_bus.xfer(1'b0, 1'b0, a, 32'h0, rdat);
        chk(n, e, rdat);
    endtask
    task tick_wait;
        @(negedge ref_clk);
        while (!countTick) @(negedge ref_clk);
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        ticks <= ticks + countTick;
        rnd = $random(seed);
        {channelFlag, channelIrqEnable, channelBufferedCapable} <= rnd[11:0];
        if (rndOn) begin
            {stopMode, breakActive, waitMode, portDirectionBit} <= rnd[15:12];
        end
        if (psel && penable) slvErr <= pslverr;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run;
        end
    end
    always @(negedge ref_clk) begin
        if (chkNext) chk("count step", expNext, countValue);
        chkNext <= countTick && !rst;
        expNext <= countValue == lim ? 16'h0000 : countValue + 16'h0001;
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        rd(`TCC_ADDR_CTRL, 32'h20, "ctrl reset");
        rd(`TCC_ADDR_ROUTE, 32'h0, "route reset");
        rd(12'h0FC, 32'h0, "unmapped");
        @(negedge ref_clk) chk("slave error", 1, slvErr);
        for (s = 0; s < 7; s++) begin
            wr(`TCC_ADDR_CTRL, s);
            tick_wait;
            t = cyc;
            tick_wait;
            chk("tick gap", 1 << s, cyc - t);
        end
        wr(`TCC_ADDR_CTRL, 32'h7);
        portDirectionBit <= 1'b1;
        @(negedge ref_clk) t = ticks;
        repeat (5) begin
            @(posedge ref_clk) extClockPin <= 1'b1;
            repeat (2) @(posedge ref_clk);
            extClockPin <= 1'b0;
            @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        chk("pin oe", 0, extPinOe);
        chk("ext ticks", 5, ticks - t);
        wr(`TCC_ADDR_CTRL, 32'h20);
        @(negedge ref_clk) chk("pin dir", 1, extPinOe);
        wr(`TCC_ADDR_CTRL, 32'h30);
        rd(`TCC_ADDR_CTRL, 32'h20, "clear reads 0");
        rd(`TCC_ADDR_CNT_LOW, 32'h0, "count cleared");
        $display("test reset and clock select ended");
        wr(`TCC_ADDR_CTRL, 32'h0);
        repeat (9) @(posedge ref_clk);
        wr(`TCC_ADDR_CTRL, 32'h20);
        @(negedge ref_clk) v = countValue;
        rd(`TCC_ADDR_CNT_HIGH, v[15:8], "high byte");
        wr(`TCC_ADDR_CTRL, 32'h0);
        wr(`TCC_ADDR_CTRL, 32'h20);
        i_bus.xfer(1'b0, 1'b0, `TCC_ADDR_CNT_HIGH, 32'h0, rdat);
        rd(`TCC_ADDR_CNT_LOW, v[7:0], "latched low");
        $display("test latch ended");
        wr(`TCC_ADDR_CTRL, 32'h30);
        wr(`TCC_ADDR_WRAP_LIMIT, 32'h3);
        lim = 16'h3;
        wr(`TCC_ADDR_CTRL, 32'h40);
        repeat (12) @(posedge ref_clk);
        wr(`TCC_ADDR_CTRL, 32'h60);
        wr(`TCC_ADDR_CTRL, 32'hE0);
        rd(`TCC_ADDR_CTRL, 32'hE0, "flag held");
        @(posedge ref_clk) breakActive <= 1'b1;
        wr(`TCC_ADDR_CTRL, 32'h60);
        @(negedge ref_clk) chk("irq in break", 1, wrapIrq);
        @(posedge ref_clk) breakActive <= 1'b0;
        wr(`TCC_ADDR_CTRL, 32'h60);
        @(negedge ref_clk) chk("irq cleared", 0, wrapIrq);
        $display("test wrap flag ended");
        wr(`TCC_ADDR_CTRL, 32'h40);
        @(posedge ref_clk) waitMode <= 1'b1;
        wr(`TCC_ADDR_ROUTE, 32'hF);
        wr(`TCC_ADDR_ROUTE, 32'h5, 1'b1);
        @(negedge ref_clk) chk("wake", 1, wakeRequest);
        @(posedge ref_clk) waitMode <= 1'b0;
        rd(`TCC_ADDR_ROUTE, 32'h5, "wait access");
        t = $random(seed);
        wr(`TCC_ADDR_ROUTE, t[3:0]);
        rd(`TCC_ADDR_ROUTE, t[3:0], "route rw");
        wr(`TCC_ADDR_CTRL, {$random(seed)} % 7 + 32'h40);
        rndOn = 1;
        repeat (400) @(posedge ref_clk);
        $display("test random modes ended");
        complete_run;
    end
endmodule // tb

// >>> tb/tcc_apb_master.sv
// apb master model standing in for the cpu and dma controller
`timescale 1ns/1ns
module tcc_apb_master (
    input  logic        ref_clk,
    input  logic        pready,
    input  logic [31:0] prdata,
    output logic        psel = 0, penable = 0, pwrite = 0, dmaAccess = 0,
    output logic [11:0] paddr = 0,
    output logic [31:0] pwdata = 0
);
    // ==================================================
    // one transfer, request held until pready
    task xfer(input logic w, dm, input logic [11:0] a,
              input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        dmaAccess <= dm;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (!pready) @(posedge ref_clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // tcc_apb_master

// >>> tb/tcc_core_control_assertions.sv
// assertion checker for the timer core control block
`timescale 1ns/1ns
module tcc_core_control_checker (
    input logic        ref_clk, rst, waitMode, stopMode, breakActive,
    input logic        wrapIrq, wakeRequest, countTick,
    input logic        portDirectionBit, extPinOe,
    input logic [3:0]  channelFlag, channelIrqEnable, channelCpuIrq,
    input logic [3:0]  channelDmaReq, channelBufferedCapable,
    input logic [15:0] countValue
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==================================================
    // counter and requests
    sequence s_step; countTick && countValue != 16'h0000; endsequence
    property p_step; s_step |=> countValue != $past(countValue); endproperty
    a_step: assert property (p_step) else $error("no step");
    property p_hold; !countTick |=> $stable(countValue) || countValue == 0;
    endproperty
    a_hold: assert property (p_hold) else $error("count moved");
    property p_brk; breakActive |-> !countTick; endproperty
    a_brk: assert property (p_brk) else $error("tick in break");
    property p_stop; stopMode |-> !countTick; endproperty
    a_stop: assert property (p_stop) else $error("tick in stop");
    property p_oe; !portDirectionBit |-> !extPinOe; endproperty
    a_oe: assert property (p_oe) else $error("pin driven");
    property p_excl; (channelCpuIrq & channelDmaReq) == 4'h0; endproperty
    a_excl: assert property (p_excl) else $error("both routes");
    property p_en; ((channelCpuIrq | channelDmaReq)
        & ~(channelFlag & channelIrqEnable)) == 4'h0; endproperty
    a_en: assert property (p_en) else $error("request unasked");
    property p_buf; (channelDmaReq & channelBufferedCapable) == 4'h0;
    endproperty
    a_buf: assert property (p_buf) else $error("dma in buffered");
    property p_wake;
        wakeRequest == (waitMode && (wrapIrq || |channelCpuIrq)); endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");
endmodule // tcc_core_control_checker
bind tcc_core_control tcc_core_control_checker i_chk (.*);
